// file: pkg/scp_pkg.sv
// Purpose: constants and carriers shared by the serial control port
// Assumes: 20 MHz system clock, classic wishbone with 32-bit data
// Notes: offsets are byte addresses on the wishbone side
package scp_pkg;

  // ****************************************
  // serial frame
  // ****************************************
  localparam int SCP_FRAME_BITS = 16;
  localparam logic [4:0] SCP_CNT_OVER = 5'h11;
  localparam logic [4:0] SCP_CNT_FULL = 5'h10;

  typedef struct packed {
    logic [4:0] addr;
    logic       wr;
    logic       unused_bit;
    logic [7:0] data;
    logic       parity;
  } scp_frame_t;

  // live health inputs that build the diagnostics word
  typedef struct packed {
    logic fault_flag;
    logic ignition_status;
    logic watchdog_fault_bit;
    logic thermal_ok;
    logic prereg_ok;
    logic buck_ok;
    logic vcc_ok;
    logic pump_rail_ok;
    logic protected_5v_ok;
    logic aux_5v_b_ok;
    logic aux_5v_a_ok;
    logic transceiver_5v_ok;
    logic rail_3p3_ok;
  } scp_health_t;

  localparam int SCP_HEALTH_W = 13;
  localparam logic [12:0] SCP_HEALTH_RST = 13'h0fff;

  // ****************************************
  // wishbone map
  // ****************************************
  localparam logic [7:0] SCP_OFS_HEALTH = 8'h00;
  localparam logic [7:0] SCP_OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] SCP_OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] SCP_OFS_LAST = 8'h0c;
  localparam logic [7:0] SCP_OFS_REGS = 8'h80;

  // interrupt status bits
  localparam int SCP_IRQ_W = 3;
  localparam int SCP_IRQ_DONE = 0;
  localparam int SCP_IRQ_ERR = 1;
  localparam int SCP_IRQ_PAR = 2;
  localparam logic [2:0] SCP_IRQ_RST = 3'h0;

  // bit of the last-frame register that mirrors the transfer error
  localparam int SCP_LAST_SE_BIT = 16;

  typedef enum logic [1:0] {
    SCP_IDLE = 2'b00,
    SCP_SHIFT = 2'b01,
    SCP_CLOSE = 2'b11
  } scp_state_t;

endpackage

// file: logic/scp_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: input is asynchronous to clk_i
// Notes: only the second stage leaves the module
module scp_sync
  import scp_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and result
  input wire logic d_i,
  output logic q_o
);

  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

// file: logic/scp_serial_port.sv
// Purpose: sixteen-bit serial slave port with wishbone register access
// Assumes: serial pins are asynchronous and slow against clk_i
// Notes: the answer shifted out belongs to the previous frame
//
// Notes on behaviour
// - rising serial clock shifts input bit in
// - strobe high: ignore clock, data out released
// - exactly sixteen edges commit and clear diagnostics
// - other edge count: discard, set transfer error
// - output msb first, advance on falling clock
// - fault flag out as soon as strobe falls
// - address, write flag, unused, data, parity layout
// - write only when flag set, else read
// - flag picks diagnostics or register contents out
// - every frame holds odd count of ones
// - parity never stored, fresh each output
// - write answer carries full diagnostics word
// - read answer carries seven diagnostics plus data
//
// Our own choices: the Wishbone slave port and the register addresses.
module scp_serial_port
  import scp_pkg::*;
#(
  parameter int REG_COUNT = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // interrupt
  output logic irq_o,
  // serial pins
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic frame_strobe_n_i,
  output logic sdo_o,
  output logic sdo_oe_o
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic sck_s;
  logic sdi_s;
  logic strobe_n_s;

  scp_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sck_i),
    .q_o(sck_s)
  );

  scp_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sdi_i),
    .q_o(sdi_s)
  );

  // idle strobe is high, so the synchroniser resets high
  scp_sync #(.RST_VAL(1'b1)) u_sync_str (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(frame_strobe_n_i),
    .q_o(strobe_n_s)
  );

  // ****************************************
  // edge detection
  // ****************************************
  logic sck_prev_ff;
  logic strobe_prev_ff;
  logic sck_rise;
  logic sck_fall;
  logic str_fall;
  logic str_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_ff <= 1'b0;
      strobe_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_s;
      strobe_prev_ff <= strobe_n_s;
    end
  end

  // clock edges count only inside a frame
  assign sck_rise = sck_s & ~sck_prev_ff & ~strobe_n_s;
  assign sck_fall = ~sck_s & sck_prev_ff & ~strobe_n_s;
  assign str_fall = ~strobe_n_s & strobe_prev_ff;
  assign str_rise = strobe_n_s & ~strobe_prev_ff;

  // ****************************************
  // frame state
  // ****************************************
  scp_state_t state_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= SCP_IDLE;
    end else begin
      case (state_ff)
        SCP_IDLE: begin
          if (str_fall) begin
            state_ff <= SCP_SHIFT;
          end
        end
        SCP_SHIFT: begin
          if (str_rise) begin
            state_ff <= SCP_CLOSE;
          end
        end
        SCP_CLOSE: begin
          state_ff <= SCP_IDLE;
        end
        default: begin
          state_ff <= SCP_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // receive path
  // ****************************************
  logic [15:0] rx_ff;
  logic [4:0] edge_cnt_ff;
  scp_frame_t rx_frame;

  assign rx_frame = rx_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ff <= 16'h0000;
    end else if (sck_rise) begin
      rx_ff <= {rx_ff[14:0], sdi_s};
    end
  end

  // saturates one past sixteen so long frames stay detectable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_cnt_ff <= 5'h00;
    end else if (str_fall) begin
      edge_cnt_ff <= 5'h00;
    end else if (sck_rise && edge_cnt_ff != SCP_CNT_OVER) begin
      edge_cnt_ff <= edge_cnt_ff + 5'h01;
    end
  end

  logic frame_good;
  logic frame_bad;
  logic rx_par_bad;

  assign frame_good = (state_ff == SCP_CLOSE) && (edge_cnt_ff == SCP_CNT_FULL);
  assign frame_bad = (state_ff == SCP_CLOSE) && (edge_cnt_ff != SCP_CNT_FULL);
  // the unused bit only counts toward parity
  assign rx_par_bad = ~(^rx_ff);

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] regs_ff [REG_COUNT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= 8'h00;
      end
    end else if (frame_good && rx_frame.wr) begin
      regs_ff[rx_frame.addr] <= rx_frame.data;
    end
  end

  // ****************************************
  // answer selection
  // ****************************************
  logic answer_read_ff;
  logic [7:0] answer_data_ff;
  logic se_ff;

  // a bad frame keeps the previous answer kind and data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      answer_read_ff <= 1'b0;
      answer_data_ff <= 8'h00;
    end else if (frame_good) begin
      answer_read_ff <= ~rx_frame.wr;
      answer_data_ff <= regs_ff[rx_frame.addr];
    end
  end

  // good frame resets the diagnostic error, bad one sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      se_ff <= 1'b0;
    end else if (frame_bad) begin
      se_ff <= 1'b1;
    end else if (frame_good) begin
      se_ff <= 1'b0;
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  scp_health_t health_ff;
  logic [15:0] tx_word;
  logic [15:0] tx_ff;

  // built with live health bits at strobe fall, parity fresh each time
  always_comb begin
    if (answer_read_ff) begin
      tx_word = {health_ff.fault_flag, se_ff, health_ff.ignition_status,
                 health_ff.watchdog_fault_bit, health_ff.thermal_ok,
                 health_ff.prereg_ok, health_ff.buck_ok, answer_data_ff, 1'b0};
    end else begin
      tx_word = {health_ff.fault_flag, se_ff, health_ff.ignition_status,
                 health_ff.watchdog_fault_bit, health_ff.thermal_ok,
                 health_ff.prereg_ok, health_ff.buck_ok, health_ff.vcc_ok,
                 health_ff.pump_rail_ok, health_ff.protected_5v_ok,
                 health_ff.aux_5v_b_ok, health_ff.aux_5v_a_ok,
                 health_ff.transceiver_5v_ok, health_ff.rail_3p3_ok, 1'b0, 1'b0};
    end
    tx_word[0] = ~(^tx_word[15:1]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ff <= 16'h0000;
    end else if (str_fall) begin
      tx_ff <= tx_word;
    end else if (sck_fall) begin
      tx_ff <= {tx_ff[14:0], 1'b0};
    end
  end

  // fault flag leaves in the same cycle the strobe fall is seen
  assign sdo_o = str_fall ? tx_word[15] : tx_ff[15];
  assign sdo_oe_o = ~strobe_n_s;

  // ****************************************
  // wishbone slave
  // ****************************************
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [SCP_IRQ_W-1:0] irq_stat_ff;
  logic [SCP_IRQ_W-1:0] irq_mask_ff;
  logic [16:0] last_ff;
  logic bus_req;
  logic bus_wr;
  logic [SCP_IRQ_W-1:0] irq_clr;
  logic [SCP_IRQ_W-1:0] irq_set;

  assign bus_req = cyc_i & stb_i & ~ack_ff;
  assign bus_wr = bus_req & we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (bus_req) begin
      if (adr_i == SCP_OFS_HEALTH) begin
        dat_ff <= {19'h0, health_ff};
      end else if (adr_i == SCP_OFS_IRQ_STAT) begin
        dat_ff <= {29'h0, irq_stat_ff};
      end else if (adr_i == SCP_OFS_IRQ_MASK) begin
        dat_ff <= {29'h0, irq_mask_ff};
      end else if (adr_i == SCP_OFS_LAST) begin
        dat_ff <= {15'h0, last_ff};
      end else if (adr_i >= SCP_OFS_REGS && adr_i[1:0] == 2'b00) begin
        dat_ff <= {24'h0, regs_ff[adr_i[6:2]]};
      end else begin
        dat_ff <= 32'h0000_0000;
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      health_ff <= SCP_HEALTH_RST;
    end else if (bus_wr && adr_i == SCP_OFS_HEALTH) begin
      if (sel_i[0]) begin
        health_ff[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        health_ff[12:8] <= dat_i[12:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= SCP_IRQ_RST;
    end else if (bus_wr && adr_i == SCP_OFS_IRQ_MASK && sel_i[0]) begin
      irq_mask_ff <= dat_i[SCP_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_ff <= 17'h00000;
    end else if (state_ff == SCP_CLOSE) begin
      last_ff <= {frame_bad, rx_ff};
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign irq_set = {frame_good & rx_par_bad, frame_bad, frame_good};
  assign irq_clr = (bus_wr && adr_i == SCP_OFS_IRQ_STAT && sel_i[0]) ? dat_i[SCP_IRQ_W-1:0] : 3'h0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= SCP_IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

endmodule

// file: verification/scp_chk_asserts.sv
// Purpose: port checks for the serial port
// Assumes: one clock domain
// Notes: sees top ports only
module scp_chk
  import scp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic irq_o,
  // serial
  input wire logic sck_i,
  input wire logic frame_strobe_n_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = cyc_i && stb_i && !ack_o;
  AST_ACK_ONE: assert property (req |=> ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
  AST_RST_QUIET: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !sdo_oe_o)
    else $error("busy after reset");
  AST_GAP_READ: assert property (req && !we_i && adr_i inside {[8'h10:8'h7f]} |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_MASK_OFF: assert property (req && we_i && adr_i == SCP_OFS_IRQ_MASK && sel_i[0] && dat_i[2:0] == 3'h0
    |=> !irq_o) else $error("irq with mask clear");
  // a frame closing late would set a bit again, so the strobe must have rested first
  AST_STAT_CLR: assert property (frame_strobe_n_i [*6] ##0 (req && we_i && adr_i == SCP_OFS_IRQ_STAT
    && sel_i[0] && dat_i[2:0] == 3'h7) |=> !irq_o) else $error("irq after clear");
  AST_OE_IDLE: assert property (frame_strobe_n_i [*4] |-> !sdo_oe_o)
    else $error("driving while idle");
  AST_OE_RISE: assert property ($fell(frame_strobe_n_i) |-> ##[1:4] sdo_oe_o)
    else $error("no output at frame start");
  AST_SDO_FALL: assert property (sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o)
    |-> !$past(sck_i) || !$past(sck_i, 2) || !$past(sck_i, 3)) else $error("bit moved off fall");
  cover property ($fell(frame_strobe_n_i));
  cover property ($rose(irq_o));
  cover property (ack_o && we_i);
endmodule
bind scp_serial_port scp_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .irq_o(irq_o), .sck_i(sck_i), .frame_strobe_n_i(frame_strobe_n_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o));

// file: verification/scp_mst.sv
// Purpose: serial master model
// Assumes: 400 ns serial clock
// Notes: clock rests high outside frames
module scp_mst (
  // serial pins
  output logic sck_o,
  output logic sdi_o,
  output logic strobe_n_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // frames
  // ****
  initial begin
    sck_o = 1'b1;
    sdi_o = 1'b0;
    strobe_n_o = 1'b1;
  end
  // odd offset keeps pin edges away from the sampling clock
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0;
    #13;
    strobe_n_o = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      if (i < 16)
        r[15 - i] = sdo_i;
      sck_o = 1'b0;
      sdi_o = (i < 16) ? w[15 - i] : 1'b0;
      #200;
      sck_o = 1'b1;
      #200;
    end
    strobe_n_o = 1'b1;
    sdi_o = 1'b0;
    #1000;
  endtask
  // clock and data noise while not selected
  task automatic noise();
    repeat (3) begin
      sck_o = 1'b0;
      sdi_o = 1'b1;
      #200;
      sck_o = 1'b1;
      #200;
    end
    sdi_o = 1'b0;
  endtask
endmodule

// file: verification/testbench.sv
// Purpose: self-checking bench for the serial port
// Assumes: master model drives the serial pins
// Notes: each answer belongs to the previous frame
module testbench
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic ack_o, irq_o, sck_i, sdi_i, frame_strobe_n_i, sdo_o, sdo_oe_o;
  logic [15:0] r;
  int fail_count = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  scp_serial_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .sck_i(sck_i), .sdi_i(sdi_i), .frame_strobe_n_i(frame_strobe_n_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o));
  // a released output shows the inverse, so a late enable spoils the sampled bit
  scp_mst u_mst (.sck_o(sck_i), .sdi_o(sdi_i), .strobe_n_o(frame_strobe_n_i),
    .sdo_i(sdo_oe_o ? sdo_o : ~sdo_o));
  // ****
  // helpers
  // ****
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      k++;
      if (k > 20) begin
        fail_count++;
        end_sim();
      end
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("reg", rd, e);
  endtask
  function automatic logic [15:0] frm(input logic [4:0] a, input logic w, input logic [7:0] d);
    logic [14:0] b;
    b = {a, w, 1'b0, d};
    return {b, ~^b};
  endfunction
  function automatic logic [15:0] ans(input logic rk, input logic se, input logic [12:0] h,
    input logic [7:0] d);
    logic [14:0] b;
    b = rk ? {h[12], se, h[11:7], d} : {h[12], se, h[11:0], 1'b0};
    return {b, ~^b};
  endfunction
  task automatic fx(input logic [15:0] f, input int n, input logic [15:0] e);
    u_mst.xfer(f, n, r);
    chk("ans", 32'(r), 32'(e));
    @(posedge clk_i);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rdc(SCP_OFS_HEALTH, 32'(SCP_HEALTH_RST));
    rdc(8'h40, 32'h0);
    chk("irq", 32'(irq_o), 32'h0);
  endtask
  task automatic t_frames();
    u_mst.noise();
    chk("oe", 32'(sdo_oe_o), 32'h0);
    fx(frm(5'h03, 1'b1, 8'ha5), 16, ans(1'b0, 1'b0, SCP_HEALTH_RST, 8'h00));
    fx(frm(5'h03, 1'b0, 8'h5a), 16, ans(1'b0, 1'b0, SCP_HEALTH_RST, 8'h00));
    rdc(8'h8c, 32'ha5);
  endtask
  task automatic t_bad();
    fx(frm(5'h04, 1'b1, 8'hff), 15, ans(1'b1, 1'b0, SCP_HEALTH_RST, 8'ha5));
    rdc(8'h90, 32'h0);
    fx(frm(5'h04, 1'b1, 8'hff), 17, ans(1'b1, 1'b1, SCP_HEALTH_RST, 8'ha5));
    rdc(8'h90, 32'h0);
    rdc(SCP_OFS_LAST, {15'h0, 1'b1, frm(5'h04, 1'b1, 8'hff) << 1});
    rdc(SCP_OFS_IRQ_STAT, 32'h3);
  endtask
  task automatic t_fault();
    fx(frm(5'h00, 1'b1, 8'h00), 16, ans(1'b1, 1'b1, SCP_HEALTH_RST, 8'ha5));
    wb(1'b1, SCP_OFS_HEALTH, 32'h15a3);
    rdc(SCP_OFS_HEALTH, 32'h15a3);
    fx(frm(5'h03, 1'b0, 8'h00), 16, ans(1'b0, 1'b0, 13'h15a3, 8'h00));
    fx(frm(5'h07, 1'b1, 8'h96), 16, ans(1'b1, 1'b0, 13'h15a3, 8'ha5));
    rdc(8'h9c, 32'h96);
  endtask
  // a frame with even parity is still written, only flagged
  task automatic t_parity();
    logic [15:0] f;
    f = frm(5'h06, 1'b1, 8'h3c) ^ 16'h0001;
    fx(f, 16, ans(1'b0, 1'b0, 13'h15a3, 8'h00));
    rdc(8'h98, 32'h3c);
    rdc(SCP_OFS_LAST, {15'h0, 1'b0, f});
    rdc(SCP_OFS_IRQ_STAT, 32'h5);
    wb(1'b1, SCP_OFS_IRQ_MASK, 32'h4);
    chk("irq", 32'(irq_o), 32'h1);
  endtask
  task automatic t_irq();
    wb(1'b1, SCP_OFS_IRQ_MASK, 32'h2);
    chk("irq", 32'(irq_o), 32'h1);
    wb(1'b1, SCP_OFS_IRQ_STAT, 32'h2);
    chk("irq", 32'(irq_o), 32'h0);
    rdc(SCP_OFS_IRQ_STAT, 32'h1);
    wb(1'b1, SCP_OFS_IRQ_MASK, 32'h0);
    wb(1'b1, SCP_OFS_IRQ_STAT, 32'h7);
    rdc(SCP_OFS_IRQ_STAT, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_frames();
    t_bad();
    t_fault();
    t_irq();
    t_parity();
    end_sim();
  end
endmodule
